// ---- hdl/slw_defines.svh ----
// register offsets, field positions, reset values for the stack watch block
// assumes a 32-bit avalon-mm slave with word addressing in bytes
`ifndef SLW_DEFINES_SVH
`define SLW_DEFINES_SVH

// ****************************************************
// register byte offsets
// ****************************************************
`define SLW_OFF_CTRL    6'h00
`define SLW_OFF_LOWER   6'h04
`define SLW_OFF_UPPER   6'h08
`define SLW_OFF_LMASK   6'h0c
`define SLW_OFF_UMASK   6'h10
`define SLW_OFF_DATA    6'h14
`define SLW_OFF_STAT    6'h18
`define SLW_OFF_IMASK   6'h1c
`define SLW_OFF_ESTAT   6'h20
`define SLW_OFF_SAVEPC  6'h24
`define SLW_OFF_DSTAT   6'h28

// ****************************************************
// control field positions (debug_control_reg_zero)
// ****************************************************
`define SLW_C_LO_EN     0
`define SLW_C_UP_EN     1
`define SLW_C_LO_RD     2
`define SLW_C_LO_WR     3
`define SLW_C_UP_RD     4
`define SLW_C_UP_WR     5
`define SLW_C_LO_MODE   7:6
`define SLW_C_UP_MODE   9:8
`define SLW_C_LO_HW     10
`define SLW_C_UP_HW     11
`define SLW_C_LO_STK    12
`define SLW_C_UP_STK    13
`define SLW_C_LO_SUP    14
`define SLW_C_UP_SUP    15
`define SLW_C_EVT_EN    16
`define SLW_C_EXT_DBG   17
`define SLW_C_INT_DBG   18
`define SLW_C_DSI_SEL   19

// status bits: 0 mchk, 1 dsi, 2 debug event, 3 halt
`define SLW_NUM_EVT     4
`define SLW_CTRL_RST    32'h0000_0000
`define SLW_MASK_RST    32'hffff_ffff
`define SLW_DATA_RST    32'h0000_0000

`endif

// ---- hdl/slw_match.sv ----
// one address compare watchpoint, combinational hit
// assumes access fields stable in the valid cycle
`timescale 1ns/10ps
`default_nettype none
module slw_match
(
  input  wire logic          clk,
  input  wire logic          resetn,
  input  wire slw_pkg::slw_acc_t acc,
  input  wire logic          en,
  input  wire logic          rd_en,
  input  wire logic          wr_en,
  input  wire logic [1:0]    mode,
  input  wire logic          sup_only,
  input  wire logic [31:0]   cmp_addr,
  input  wire logic [31:0]   cmp_mask,
  input  wire logic [31:0]   cmp_data,
  output logic               hit
);
  import slw_pkg::*;

  // exact or masked limit only: beyond the masked block goes unseen
  wire logic a_eq  = (acc.addr == cmp_addr);
  wire logic a_msk = ((acc.addr & cmp_mask) == (cmp_addr & cmp_mask));
  wire logic d_eq  = (acc.data == cmp_data);
  wire logic type_ok = acc.write ? wr_en : rd_en;
  wire logic priv_ok = acc.supervisor == sup_only;
  logic      sel;

  always_comb
  begin
    case (mode)
      SLW_M_ADDR:  sel = a_eq;
      SLW_M_MASK:  sel = a_msk;
      SLW_M_ADATA: sel = a_eq & d_eq;
      default:     sel = 1'b0;
    endcase
  end

  assign hit = acc.valid & en & type_ok & priv_ok & sel;
endmodule : slw_match
`default_nettype wire

// ---- hdl/slw_pkg.sv ----
// types shared by the stack watch block
// assumes the defines header is compiled alongside
package slw_pkg;

  typedef enum logic [1:0]
  {
    SLW_M_ADDR  = 2'h0,
    SLW_M_MASK  = 2'h1,
    SLW_M_ADATA = 2'h3
  } slw_mode_t;

  typedef struct packed
  {
    logic        valid;
    logic        write;
    logic        supervisor;
    logic        sp_based;
    logic [31:0] addr;
    logic [31:0] data;
    logic [31:0] pc;
  } slw_acc_t;

  // gray loop: idle, wait, pend, halt and back to idle
  typedef enum logic [1:0]
  {
    SLW_S_IDLE  = 2'h0,
    SLW_S_WAIT  = 2'h1,
    SLW_S_PEND  = 2'h3,
    SLW_S_HALT  = 2'h2
  } slw_state_t;

endpackage : slw_pkg

// ---- hdl/slw_top.sv ----
// stack limit watchpoint checker with avalon-mm registers
// assumes core gives access, completion pulse, higher-priority pending
// and a bus master that holds each request until waitrequest drops
`timescale 1ns/10ps
`default_nettype none
`include "slw_defines.svh"
module slw_top
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic [5:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  input  wire slw_pkg::slw_acc_t acc,
  input  wire logic              acc_done,
  input  wire logic              hi_prio_pend,
  output logic                   abort_ff,
  output logic                   mchk_ff,
  output logic                   dsi_ff,
  output logic                   dbg_event_ff,
  output logic                   dbg_halt_ff,
  output logic                   irq_ff
);
  import slw_pkg::*;

  // ****************************************************
  // registers
  // ****************************************************
  logic [31:0] ctrl_ff, lower_ff, upper_ff, lmask_ff, umask_ff, data_ff;
  logic [31:0] savepc_ff;
  logic [`SLW_NUM_EVT-1:0] stat_ff, imask_ff;
  logic        estat_ff, dstat_ff;
  logic        ack_ff;
  logic        hw_take_q;
  slw_state_t  state_ff, nxt_state;

  // ****************************************************
  // bus decode
  // ****************************************************
  // byte lanes honoured, except on the status and interrupt mask writes, so software can update one field alone
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction : merge

  // one wait cycle: request accepted on the second edge
  wire logic req   = (avs_read | avs_write) & ~ack_ff;
  wire logic wr_go = avs_write & ack_ff;
  wire logic w_ctl = wr_go & (avs_address == `SLW_OFF_CTRL);
  wire logic w_lo  = wr_go & (avs_address == `SLW_OFF_LOWER);
  wire logic w_up  = wr_go & (avs_address == `SLW_OFF_UPPER);
  wire logic w_lm  = wr_go & (avs_address == `SLW_OFF_LMASK);
  wire logic w_um  = wr_go & (avs_address == `SLW_OFF_UMASK);
  wire logic w_dt  = wr_go & (avs_address == `SLW_OFF_DATA);
  wire logic w_st  = wr_go & (avs_address == `SLW_OFF_STAT);
  wire logic w_im  = wr_go & (avs_address == `SLW_OFF_IMASK);
  wire logic w_es  = wr_go & (avs_address == `SLW_OFF_ESTAT);
  wire logic w_ds  = wr_go & (avs_address == `SLW_OFF_DSTAT);
  // unmapped offsets read as zero and ignore writes
  logic [31:0] rd_mux;

  always_comb
  begin
    case (avs_address)
      `SLW_OFF_CTRL:   rd_mux = ctrl_ff;
      `SLW_OFF_LOWER:  rd_mux = lower_ff;
      `SLW_OFF_UPPER:  rd_mux = upper_ff;
      `SLW_OFF_LMASK:  rd_mux = lmask_ff;
      `SLW_OFF_UMASK:  rd_mux = umask_ff;
      `SLW_OFF_DATA:   rd_mux = data_ff;
      `SLW_OFF_STAT:   rd_mux = {28'h0, stat_ff};
      `SLW_OFF_IMASK:  rd_mux = {28'h0, imask_ff};
      `SLW_OFF_ESTAT:  rd_mux = {31'h0, estat_ff};
      `SLW_OFF_SAVEPC: rd_mux = savepc_ff;
      `SLW_OFF_DSTAT:  rd_mux = {31'h0, dstat_ff};
      default:         rd_mux = 32'h0;
    endcase
  end

  // ****************************************************
  // watchpoints
  // ****************************************************
  // both watches share the one data compare value
  logic lo_hit, up_hit;

  slw_match u_lower
  (
    .clk      (clk),
    .resetn   (resetn),
    .acc      (acc),
    .en       (ctrl_ff[`SLW_C_LO_EN]),
    .rd_en    (ctrl_ff[`SLW_C_LO_RD]),
    .wr_en    (ctrl_ff[`SLW_C_LO_WR]),
    .mode     (ctrl_ff[`SLW_C_LO_MODE]),
    .sup_only (ctrl_ff[`SLW_C_LO_SUP]),
    .cmp_addr (lower_ff),
    .cmp_mask (lmask_ff),
    .cmp_data (data_ff),
    .hit      (lo_hit)
  );

  slw_match u_upper
  (
    .clk      (clk),
    .resetn   (resetn),
    .acc      (acc),
    .en       (ctrl_ff[`SLW_C_UP_EN]),
    .rd_en    (ctrl_ff[`SLW_C_UP_RD]),
    .wr_en    (ctrl_ff[`SLW_C_UP_WR]),
    .mode     (ctrl_ff[`SLW_C_UP_MODE]),
    .sup_only (ctrl_ff[`SLW_C_UP_SUP]),
    .cmp_addr (upper_ff),
    .cmp_mask (umask_ff),
    .cmp_data (data_ff),
    .hit      (up_hit)
  );

  // ****************************************************
  // ownership and action
  // ****************************************************
  wire logic ext_dbg = ctrl_ff[`SLW_C_EXT_DBG];
  wire logic evt_en  = ctrl_ff[`SLW_C_EVT_EN];
  wire logic lo_stk  = ctrl_ff[`SLW_C_LO_STK];
  wire logic up_stk  = ctrl_ff[`SLW_C_UP_STK];
  wire logic lo_hw   = ctrl_ff[`SLW_C_LO_HW];
  wire logic up_hw   = ctrl_ff[`SLW_C_UP_HW];

  // software checks need no internal debug
  wire logic sw_viol = (lo_hit & lo_stk & ~lo_hw) | (up_hit & up_stk & ~up_hw);
  wire logic hw_viol = ext_dbg & acc.sp_based &
                       ((lo_hit & lo_stk & lo_hw) | (up_hit & up_stk & up_hw));
  // software-owned stack hit makes no event
  wire logic plain_hit = evt_en & ((lo_hit & ~lo_stk) | (up_hit & ~up_stk));
  wire logic hw_take  = hw_viol & ~sw_viol;
  // an aborted access never completes, so it cannot wait for an event
  wire logic dbg_pend = (hw_take | plain_hit) & ~sw_viol;
  wire logic sel_dsi  = ctrl_ff[`SLW_C_DSI_SEL];
  logic      dbg_fire;
  logic [`SLW_NUM_EVT-1:0] evt;

  // ****************************************************
  // debug event sequencing
  // ****************************************************
  // a completed access keeps its event pending until nothing of higher
  // priority is up, so a late release still gets its halt
  // wait for completion
  always_comb
  begin
    nxt_state = state_ff;
    dbg_fire  = 1'b0;
    case (state_ff)
      SLW_S_IDLE:
        if (dbg_pend)
          nxt_state = SLW_S_WAIT;
      SLW_S_WAIT:
        if (acc_done)
          nxt_state = SLW_S_PEND;
      SLW_S_PEND:
        if (!hi_prio_pend)
        begin
          dbg_fire  = 1'b1;
          nxt_state = SLW_S_HALT;
        end
      SLW_S_HALT:
        if (w_ds)
          nxt_state = SLW_S_IDLE;
      default:
        nxt_state = SLW_S_IDLE;
    endcase
  end

  assign evt = {dbg_fire, dbg_fire, sw_viol & sel_dsi, sw_viol & ~sel_dsi};

  // ****************************************************
  // sequential
  // ****************************************************
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      ack_ff       <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
      ctrl_ff      <= `SLW_CTRL_RST;
      lower_ff     <= 32'h0;
      upper_ff     <= 32'h0;
      lmask_ff     <= `SLW_MASK_RST;
      umask_ff     <= `SLW_MASK_RST;
      data_ff      <= `SLW_DATA_RST;
      imask_ff     <= 4'h0;
    end
    else
    begin
      ack_ff       <= req;
      avs_waitrequest <= ~req;
      avs_readdata <= req ? rd_mux : avs_readdata;
      if (w_ctl) ctrl_ff  <= merge(ctrl_ff, avs_writedata, avs_byteenable);
      if (w_lo)  lower_ff <= merge(lower_ff, avs_writedata, avs_byteenable);
      if (w_up)  upper_ff <= merge(upper_ff, avs_writedata, avs_byteenable);
      if (w_lm)  lmask_ff <= merge(lmask_ff, avs_writedata, avs_byteenable);
      if (w_um)  umask_ff <= merge(umask_ff, avs_writedata, avs_byteenable);
      if (w_dt)  data_ff  <= merge(data_ff, avs_writedata, avs_byteenable);
      if (w_im)  imask_ff <= avs_writedata[`SLW_NUM_EVT-1:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_ff  <= SLW_S_IDLE;
      stat_ff   <= 4'h0;
      estat_ff  <= 1'b0;
      dstat_ff  <= 1'b0;
      savepc_ff <= 32'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      // set beats write-one-clear
      stat_ff  <= (stat_ff & ~({4{w_st}} & avs_writedata[3:0])) | evt;
      estat_ff <= (estat_ff & ~(w_es & avs_writedata[0])) |
                  (dbg_fire & hw_take_q);
      dstat_ff <= (dstat_ff & ~(w_ds & avs_writedata[0])) |
                  (dbg_fire & ~hw_take_q);
      if (sw_viol)
        savepc_ff <= acc.pc;
    end
  end

  // remembers whether the pending debug event was stack-owned;
  // sampled only while idle so a later access cannot relabel it
  always_ff @(posedge clk)
  begin
    if (!resetn)
      hw_take_q <= 1'b0;
    else if (state_ff == SLW_S_IDLE)
      hw_take_q <= hw_take;
  end

  // ****************************************************
  // outputs
  // ****************************************************
  // pulses last one cycle; the core must catch them on the next edge
  // abort and machine check
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      abort_ff     <= 1'b0;
      mchk_ff      <= 1'b0;
      dsi_ff       <= 1'b0;
      dbg_event_ff <= 1'b0;
      dbg_halt_ff  <= 1'b0;
      irq_ff       <= 1'b0;
    end
    else
    begin
      abort_ff     <= sw_viol;
      mchk_ff      <= sw_viol & ~sel_dsi;
      dsi_ff       <= sw_viol & sel_dsi;
      dbg_event_ff <= dbg_fire;
      dbg_halt_ff  <= (nxt_state == SLW_S_HALT);
      irq_ff       <= |(stat_ff & imask_ff);
    end
  end

endmodule : slw_top
`default_nettype wire

// ---- sim/slw_core_model.sv ----
// core load/store model: issues one access, reports completion later
// assumes the bench pulses go for one cycle with the access on req
`timescale 1ns/10ps
`default_nettype none
module slw_core_model
#(
  parameter int DLY = 3
)
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              go,
  input  wire slw_pkg::slw_acc_t req,
  input  wire logic              abort_ff,
  output var slw_pkg::slw_acc_t  acc,
  output logic                   acc_done
);
  import slw_pkg::*;
  int cnt_ff;
  // fields outside the valid cycle toggle, never a stale copy
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      acc      <= '0;
      acc_done <= 1'b0;
      cnt_ff   <= 0;
    end
    else if (go)
    begin
      acc      <= req;
      acc_done <= 1'b0;
      cnt_ff   <= DLY;
    end
    else
    begin
      // valid is the top field; the rest toggles
      acc <= {1'b0, ~acc[$bits(slw_acc_t)-2:0]};
      // an aborted access never completes
      if (abort_ff)
        cnt_ff <= 0;
      else if (cnt_ff > 0)
        cnt_ff <= cnt_ff - 1;
      acc_done <= (cnt_ff == 1) && !abort_ff;
    end
  end
endmodule : slw_core_model
`default_nettype wire

// ---- sim/slw_top_assertions.sv ----
// checker for the stack watch block, ports of slw_top only
// assumes one clock domain and synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module slw_top_assertions
(
  input wire logic              clk,
  input wire logic              resetn,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic              avs_waitrequest,
  input wire slw_pkg::slw_acc_t acc,
  input wire logic              acc_done,
  input wire logic              hi_prio_pend,
  input wire logic              abort_ff,
  input wire logic              mchk_ff,
  input wire logic              dsi_ff,
  input wire logic              dbg_event_ff,
  input wire logic              dbg_halt_ff
);
  import slw_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // completion seen since the last debug event
  logic done_q;
  always_ff @(posedge clk)
  begin
    if (!resetn)
      done_q <= 1'b0;
    else
      done_q <= acc_done | (done_q & ~dbg_event_ff);
  end

  // ****************************************************
  // violation outputs
  // ****************************************************
  a_kind_aborts: assert property ((mchk_ff || dsi_ff) |-> abort_ff)
    else $error("exception without abort");
  a_one_kind: assert property (abort_ff |-> (mchk_ff ^ dsi_ff))
    else $error("abort needs exactly one exception kind");
  a_abort_cause: assert property (abort_ff |-> $past(acc.valid))
    else $error("abort without an access");
  a_sw_no_event: assert property (abort_ff |-> !dbg_event_ff ##1 !dbg_event_ff)
    else $error("debug event after aborted access");

  // ****************************************************
  // debug event and halt
  // ****************************************************
  a_event_done: assert property (dbg_event_ff |-> $past(done_q))
    else $error("event before the access completed");
  a_event_prio: assert property (
    dbg_event_ff |-> !$past(hi_prio_pend))
    else $error("event while higher priority pending");
  a_event_halts: assert property (dbg_event_ff |-> dbg_halt_ff)
    else $error("event without halt");
  a_halt_cause: assert property ($rose(dbg_halt_ff) |-> dbg_event_ff)
    else $error("halt without event");
  a_event_pulse: assert property (dbg_event_ff |=> !dbg_event_ff)
    else $error("event longer than one cycle");
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
endmodule : slw_top_assertions

bind slw_top slw_top_assertions i_slw_top_assertions
(
  .clk(clk), .resetn(resetn), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .acc(acc), .acc_done(acc_done),
  .hi_prio_pend(hi_prio_pend), .abort_ff(abort_ff), .mchk_ff(mchk_ff),
  .dsi_ff(dsi_ff), .dbg_event_ff(dbg_event_ff), .dbg_halt_ff(dbg_halt_ff)
);
`default_nettype wire

// ---- sim/slw_top_tb_top.sv ----
// bench for the stack watch block over avalon-mm
// assumes slw_top, the core model and the checker compiled first
`timescale 1ns/10ps
`default_nettype none
`include "slw_defines.svh"
module slw_top_tb_top;
  import slw_pkg::*;
  localparam logic [31:0] LSW = 32'h0001_1005;
  localparam logic [31:0] UHW = 32'h0003_2812;
  logic        clk, resetn, avs_read, avs_write, avs_waitrequest;
  logic        go, clr, hi_prio_pend, im_on, dflag, acc_done, abort_ff;
  logic        mchk_ff, dsi_ff, dbg_event_ff, dbg_halt_ff, irq_ff;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  seen, be, avs_byteenable;
  slw_acc_t    acc, req;
  int          failures, checks, n;
  int          cyc = 0;

  slw_top i_slw_top
  (
    .clk(clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .acc(acc), .acc_done(acc_done), .hi_prio_pend(hi_prio_pend),
    .abort_ff(abort_ff), .mchk_ff(mchk_ff), .dsi_ff(dsi_ff),
    .dbg_event_ff(dbg_event_ff), .dbg_halt_ff(dbg_halt_ff), .irq_ff(irq_ff)
  );
  slw_core_model i_slw_core_model
  (
    .clk(clk), .resetn(resetn), .go(go), .req(req),
    .abort_ff(abort_ff), .acc(acc), .acc_done(acc_done)
  );

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // pulses are caught here so a late one is not missed
  always @(posedge clk)
  begin
    seen <= (clr || !resetn) ? 4'h0 :
            seen | {abort_ff, mchk_ff, dsi_ff, dbg_event_ff};
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      failures++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= w;
    avs_read       <= !w;
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rd

  // exp bits: abort, machine check, storage interrupt, debug event
  task automatic run(input logic [31:0] ctl, input logic [31:0] ad,
                     input logic w, sp, sup, pd, input logic [31:0] dat,
                     input logic [3:0] exp);
    logic [31:0] q;
    wr(`SLW_OFF_CTRL, ctl);
    @(posedge clk);
    clr          <= 1'b1;
    go           <= 1'b1;
    hi_prio_pend <= pd;
    req <= '{1'b1, w, sup, sp, ad, dat, 32'h4000_0000 | ad};
    @(posedge clk);
    clr <= 1'b0;
    go  <= 1'b0;
    repeat (12) @(posedge clk);
    chk({28'h0, seen}, {28'h0, exp});
    chk({31'h0, irq_ff}, {31'h0, im_on & (|exp)});
    chk({31'h0, dbg_halt_ff}, {31'h0, exp[0]});
    bus(1'b0, `SLW_OFF_STAT, 32'h0, q);
    chk(q & 32'h3, {30'h0, exp[1], exp[2]});
    rd(`SLW_OFF_ESTAT, {31'h0, exp[0] & ~dflag});
    rd(`SLW_OFF_DSTAT, {31'h0, exp[0] & dflag});
    if (exp[3])
      rd(`SLW_OFF_SAVEPC, 32'h4000_0000 | ad);
    wr(`SLW_OFF_DSTAT, 32'hffff_ffff);
    wr(`SLW_OFF_ESTAT, 32'hffff_ffff);
    wr(`SLW_OFF_STAT, 32'hffff_ffff);
    repeat (2) @(posedge clk);
    chk({31'h0, dbg_halt_ff | irq_ff}, 32'h0);
    n++;
    $display("test %0d done", n);
  endtask : run

  task automatic finish_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test

  initial
  begin
    {avs_read, avs_write, go, clr, hi_prio_pend, dflag} = '0;
    avs_address    = '0;
    avs_writedata  = '0;
    avs_byteenable = 4'hf;
    be             = 4'hf;
    req            = '0;
    im_on          = 1'b1;
    {failures, checks, n} = '0;
    resetn = 1'b0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    rd(`SLW_OFF_CTRL, 32'h0);
    rd(`SLW_OFF_IMASK, 32'h0);
    wr(`SLW_OFF_IMASK, 32'hffff_ffff);
    rd(`SLW_OFF_IMASK, 32'hf);
    wr(6'h3c, 32'h1234);
    rd(6'h3c, 32'h0);
    wr(`SLW_OFF_LOWER, 32'h1000);
    wr(`SLW_OFF_UPPER, 32'h2000);
    wr(`SLW_OFF_LMASK, 32'hffff_fff0);
    wr(`SLW_OFF_DATA, 32'ha5);
    be = 4'b0010;
    wr(`SLW_OFF_DATA, 32'hffff_ffff);
    be = 4'hf;
    rd(`SLW_OFF_DATA, 32'h0000_ffa5);
    wr(`SLW_OFF_DATA, 32'ha5);
    run(LSW, 32'h1000, 0, 0, 0, 0, 32'ha5, 4'b1100);
    run(LSW, 32'h1004, 0, 0, 0, 0, 32'ha5, 4'b0000);
    run(LSW, 32'h1000, 1, 0, 0, 0, 32'ha5, 4'b0000);
    run(LSW | 32'h8_0008, 32'h1000, 1, 0, 0, 0, 32'ha5, 4'b1010);
    run(LSW | 32'h4000, 32'h1000, 0, 0, 0, 0, 32'ha5, 4'b0000);
    run(LSW | 32'h4000, 32'h1000, 0, 0, 1, 0, 32'ha5, 4'b1100);
    run(LSW | 32'h40, 32'h1008, 0, 0, 0, 0, 32'ha5, 4'b1100);
    run(LSW | 32'hc0, 32'h1000, 0, 0, 0, 0, 32'ha5, 4'b1100);
    run(LSW | 32'hc0, 32'h1000, 0, 0, 0, 0, 32'h5a, 4'b0000);
    run(UHW, 32'h2000, 0, 0, 0, 0, 32'ha5, 4'b0000);
    run(UHW, 32'h2000, 0, 1, 0, 1, 32'ha5, 4'b0000);
    hi_prio_pend <= 1'b0;
    repeat (3) @(posedge clk);
    chk({31'h0, dbg_halt_ff}, 32'h1);
    rd(`SLW_OFF_ESTAT, 32'h1);
    wr(`SLW_OFF_DSTAT, 32'h1);
    wr(`SLW_OFF_ESTAT, 32'h1);
    wr(`SLW_OFF_STAT, 32'hf);
    run(UHW, 32'h2000, 0, 1, 0, 0, 32'ha5, 4'b0001);
    run(UHW & ~32'h2_0000, 32'h2000, 0, 1, 0, 0, 32'ha5, 4'b0000);
    dflag = 1'b1;
    run(32'h0001_0005, 32'h1000, 0, 0, 0, 0, 32'ha5, 4'b0001);
    dflag = 1'b0;
    im_on = 1'b0;
    wr(`SLW_OFF_IMASK, 32'h0);
    run(LSW, 32'h1000, 0, 0, 0, 0, 32'ha5, 4'b1100);
    wr(`SLW_OFF_IMASK, 32'hffff_ffff);
    im_on = 1'b1;
    wr(`SLW_OFF_UPPER, 32'h1000);
    run(LSW | UHW, 32'h1000, 0, 1, 0, 0, 32'ha5, 4'b1100);
    finish_test();
  end
endmodule : slw_top_tb_top
`default_nettype wire
